// >>> shared/aps_cfg.svh
// constants for the auxiliary, pointer and status load group
`ifndef APS_CFG_SVH
`define APS_CFG_SVH

`define APS_DW 16
`define APS_AW 8
`define APS_PCW 12
// opcode matches
`define APS_LAR_HI 7'h1c
`define APS_LOAD_AUX_IMMEDIATE_HI 7'h38
`define APS_MAR_HI 8'h68
`define APS_LDP_HI 8'h6f
`define APS_LOAD_PAGE_IMMEDIATE_HI 15'h3700
`define APS_LST_HI 8'h7b
// instruction field positions and widths, auxiliary register count
`define APS_B_IND 7
`define APS_B_INC 5
`define APS_B_DEC 4
`define APS_B_KEEP 3
`define APS_B_NXT 0
`define APS_B_AR 8
`define APS_B_K 0
`define APS_KW 8
`define APS_DMAW 7
`define APS_OP7_LO 9
`define APS_OP8_LO 8
`define APS_OP15_LO 1
`define APS_B_LSB 0
`define APS_NAUX 2
// status word layout
`define APS_SB_OV 15
`define APS_SB_OVM 14
`define APS_SB_INTERRUPT_MASK_BIT 13
`define APS_SB_ARP 8
`define APS_SB_DP 0
`define APS_SW_ONES_HI 4'hf
`define APS_SW_ONES_LO 6'h3f
`define APS_SW_ZERO 1'b0
// reset values and step sizes
`define APS_RST_ARP 1'b0
`define APS_RST_DP 1'b0
`define APS_RST_OV 1'b0
`define APS_RST_OVM 1'b0
`define APS_RST_INTERRUPT_MASK_BIT 1'b1
`define APS_RST_AUX 16'h0000
`define APS_RST_PC 12'h000
`define APS_PC_STEP 12'h001
`define APS_AUX_STEP 16'h0001

`endif

// >>> shared/aps_pkg.sv
// types for the auxiliary, pointer and status load group
package aps_pkg;
    typedef enum logic [2:0] {
        op_none = 3'b000,
        op_lar = 3'b001,
        op_load_aux_immediate = 3'b010,
        op_mar = 3'b011,
        op_ldp = 3'b100,
        op_load_page_immediate = 3'b101,
        op_lst = 3'b110
    } aps_op_t;
endpackage

// >>> hdl/aps_aux_bank.sv
// two auxiliary registers with load and post-update
`timescale 1ns/1ps
`default_nettype none
`include "aps_cfg.svh"
module aps_aux_bank (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic wr_sel,
    input wire logic [`APS_DW-1:0] wr_data,
    input wire logic upd_en,
    input wire logic upd_sel,
    input wire logic upd_down,
    output logic [`APS_DW-1:0] aux_zero,
    output logic [`APS_DW-1:0] aux_one
);
    logic [`APS_DW-1:0] aux_ff [`APS_NAUX];
    logic [`APS_DW-1:0] nxt_aux [`APS_NAUX];

    genvar gi;
    generate
        for (gi = 0; gi < `APS_NAUX; gi = gi + 1) begin : g_ent
            always_comb begin
                nxt_aux[gi] = aux_ff[gi];
                // load beats post-update of same register
                if (wr_en && (wr_sel == 1'(gi))) begin
                    nxt_aux[gi] = wr_data;
                end else if (upd_en && (upd_sel == 1'(gi))) begin
                    nxt_aux[gi] = upd_down ? aux_ff[gi] - `APS_AUX_STEP
                                           : aux_ff[gi] + `APS_AUX_STEP;
                end
            end
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    aux_ff[gi] <= `APS_RST_AUX;
                end else begin
                    aux_ff[gi] <= nxt_aux[gi];
                end
            end
        end
    endgenerate

    assign aux_zero = aux_ff[0];
    assign aux_one = aux_ff[1];
endmodule // aps_aux_bank
`default_nettype wire

// >>> hdl/aps_load_ops.sv
// execution of auxiliary, pointer, page and status load instructions
`timescale 1ns/1ps
`default_nettype none
`include "aps_cfg.svh"
module aps_load_ops (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [`APS_DW-1:0] instr_word,
    input wire logic [`APS_DW-1:0] mem_rdata,
    input wire logic ov_set,
    input wire logic interrupt_mask_bit_set,
    input wire logic interrupt_mask_bit_clr,
    output logic [`APS_AW-1:0] dmem_addr_ff,
    output logic dmem_rd_ff,
    output logic [`APS_DW-1:0] aux_register_zero,
    output logic [`APS_DW-1:0] aux_register_one,
    output logic aux_select_pointer_ff,
    output logic page_pointer_ff,
    output logic overflow_flag_ff,
    output logic overflow_saturate_mode_ff,
    output logic interrupt_mask_bit_ff,
    output logic [`APS_DW-1:0] status_word_ff,
    output logic [`APS_PCW-1:0] pc_ff,
    output logic pc_step_ff
);
    aps_pkg::aps_op_t in_op;
    aps_pkg::aps_op_t ex_op_ff;
    aps_pkg::aps_op_t nxt_ex_op;
    logic [`APS_DW-1:0] ex_instr_ff;
    logic [`APS_DW-1:0] nxt_ex_instr;
    logic [`APS_AW-1:0] nxt_dmem_addr;
    logic nxt_dmem_rd;
    logic nxt_arp;
    logic nxt_dp;
    logic nxt_ov;
    logic nxt_ovm;
    logic nxt_interrupt_mask_bit;
    logic [`APS_DW-1:0] nxt_status;
    logic [`APS_PCW-1:0] nxt_pc;
    logic nxt_pc_step;
    logic ex_ind;
    logic ex_keep_arp;
    logic aux_wr_en;
    logic aux_wr_sel;
    logic [`APS_DW-1:0] aux_wr_data;
    logic aux_upd_en;
    logic aux_upd_down;
    logic [`APS_DW-1:0] cur_aux;
    logic [`APS_DW-1:0] fwd_aux;

    // decode of the incoming word
    always_comb begin
        in_op = aps_pkg::op_none;
        if (instr_word[`APS_DW-1:`APS_OP7_LO] == `APS_LAR_HI) begin
            in_op = aps_pkg::op_lar;
        end else if (instr_word[`APS_DW-1:`APS_OP7_LO] == `APS_LOAD_AUX_IMMEDIATE_HI) begin
            in_op = aps_pkg::op_load_aux_immediate;
        end else if (instr_word[`APS_DW-1:`APS_OP8_LO] == `APS_MAR_HI) begin
            // immediate pointer load shares the indirect modify opcode
            in_op = aps_pkg::op_mar;
        end else if (instr_word[`APS_DW-1:`APS_OP8_LO] == `APS_LDP_HI) begin
            in_op = aps_pkg::op_ldp;
        end else if (instr_word[`APS_DW-1:`APS_OP15_LO] == `APS_LOAD_PAGE_IMMEDIATE_HI) begin
            in_op = aps_pkg::op_load_page_immediate;
        end else if (instr_word[`APS_DW-1:`APS_OP8_LO] == `APS_LST_HI) begin
            in_op = aps_pkg::op_lst;
        end
    end

    // execute stage field views
    assign ex_ind = ex_instr_ff[`APS_B_IND];
    assign ex_keep_arp = ex_instr_ff[`APS_B_KEEP];

    // auxiliary register writes and post-updates
    always_comb begin
        aux_wr_en = 1'b0;
        aux_wr_sel = ex_instr_ff[`APS_B_AR];
        aux_wr_data = mem_rdata;
        aux_upd_en = 1'b0;
        aux_upd_down = ex_instr_ff[`APS_B_DEC];
        unique case (ex_op_ff)
            aps_pkg::op_lar: begin
                aux_wr_en = 1'b1;
            end
            aps_pkg::op_load_aux_immediate: begin
                aux_wr_en = 1'b1;
                aux_wr_data = {{(`APS_DW-`APS_KW){1'b0}},
                               ex_instr_ff[`APS_B_K +: `APS_KW]};
            end
            default: begin
                aux_wr_en = 1'b0;
            end
        endcase
        if (ex_ind && (ex_op_ff == aps_pkg::op_lar ||
                       ex_op_ff == aps_pkg::op_mar ||
                       ex_op_ff == aps_pkg::op_ldp ||
                       ex_op_ff == aps_pkg::op_lst)) begin
            aux_upd_en = ex_instr_ff[`APS_B_INC] ^ ex_instr_ff[`APS_B_DEC];
        end
    end

    // status bits
    always_comb begin
        nxt_arp = aux_select_pointer_ff;
        nxt_dp = page_pointer_ff;
        nxt_ov = overflow_flag_ff;
        nxt_ovm = overflow_saturate_mode_ff;
        unique case (ex_op_ff)
            aps_pkg::op_ldp: begin
                nxt_dp = mem_rdata[`APS_B_LSB];
            end
            aps_pkg::op_load_page_immediate: begin
                nxt_dp = ex_instr_ff[`APS_B_K];
            end
            aps_pkg::op_lst: begin
                nxt_ov = mem_rdata[`APS_SB_OV];
                nxt_ovm = mem_rdata[`APS_SB_OVM];
                nxt_arp = mem_rdata[`APS_SB_ARP];
                nxt_dp = mem_rdata[`APS_SB_DP];
            end
            default: begin
                nxt_dp = page_pointer_ff;
            end
        endcase
        // next-pointer field, overrides loaded pointer
        if (ex_ind && !ex_keep_arp && (ex_op_ff == aps_pkg::op_lar ||
                                      ex_op_ff == aps_pkg::op_mar ||
                                      ex_op_ff == aps_pkg::op_ldp ||
                                      ex_op_ff == aps_pkg::op_lst)) begin
            nxt_arp = ex_instr_ff[`APS_B_NXT];
        end
        // accumulator overflow set wins over a load of zero
        if (ov_set) begin
            nxt_ov = 1'b1;
        end
        // interrupt mask untouched by status load
        nxt_interrupt_mask_bit = interrupt_mask_bit_ff;
        if (interrupt_mask_bit_set) begin
            nxt_interrupt_mask_bit = 1'b1;
        end else if (interrupt_mask_bit_clr) begin
            nxt_interrupt_mask_bit = 1'b0;
        end
        nxt_status = {nxt_ov, nxt_ovm, nxt_interrupt_mask_bit, `APS_SW_ONES_HI, nxt_arp,
                      `APS_SW_ONES_LO, `APS_SW_ZERO, nxt_dp};
    end

    // forwarded current auxiliary register for the next address
    always_comb begin
        cur_aux = nxt_arp ? aux_register_one : aux_register_zero;
        fwd_aux = cur_aux;
        if (aux_wr_en && (aux_wr_sel == nxt_arp)) begin
            fwd_aux = aux_wr_data;
        end else if (aux_upd_en &&
                     (aux_select_pointer_ff == nxt_arp)) begin
            fwd_aux = aux_upd_down ? cur_aux - `APS_AUX_STEP
                                   : cur_aux + `APS_AUX_STEP;
        end
    end

    // operand address and pipeline advance
    always_comb begin
        nxt_ex_op = instr_valid ? in_op : aps_pkg::op_none;
        nxt_ex_instr = instr_word;
        if (instr_word[`APS_B_IND]) begin
            nxt_dmem_addr = fwd_aux[`APS_AW-1:0];
        end else begin
            nxt_dmem_addr = {nxt_dp, instr_word[`APS_DMAW-1:0]};
        end
        nxt_dmem_rd = instr_valid && (in_op == aps_pkg::op_lar ||
                                      in_op == aps_pkg::op_ldp ||
                                      in_op == aps_pkg::op_lst);
    end

    // program counter advance
    always_comb begin
        nxt_pc_step = (ex_op_ff != aps_pkg::op_none);
        nxt_pc = pc_ff;
        if (nxt_pc_step) begin
            nxt_pc = pc_ff + `APS_PC_STEP;
        end
    end

    // pipeline and operand address registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ex_op_ff <= aps_pkg::op_none;
            ex_instr_ff <= {`APS_DW{1'b0}};
            dmem_addr_ff <= {`APS_AW{1'b0}};
            dmem_rd_ff <= 1'b0;
        end else begin
            ex_op_ff <= nxt_ex_op;
            ex_instr_ff <= nxt_ex_instr;
            dmem_addr_ff <= nxt_dmem_addr;
            dmem_rd_ff <= nxt_dmem_rd;
        end
    end

    // status bit registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_select_pointer_ff <= `APS_RST_ARP;
            page_pointer_ff <= `APS_RST_DP;
            overflow_flag_ff <= `APS_RST_OV;
            overflow_saturate_mode_ff <= `APS_RST_OVM;
            interrupt_mask_bit_ff <= `APS_RST_INTERRUPT_MASK_BIT;
            status_word_ff <= {`APS_RST_OV, `APS_RST_OVM, `APS_RST_INTERRUPT_MASK_BIT,
                               `APS_SW_ONES_HI, `APS_RST_ARP,
                               `APS_SW_ONES_LO, `APS_SW_ZERO, `APS_RST_DP};
        end else begin
            aux_select_pointer_ff <= nxt_arp;
            page_pointer_ff <= nxt_dp;
            overflow_flag_ff <= nxt_ov;
            overflow_saturate_mode_ff <= nxt_ovm;
            interrupt_mask_bit_ff <= nxt_interrupt_mask_bit;
            status_word_ff <= nxt_status;
        end
    end

    // program counter registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_ff <= `APS_RST_PC;
            pc_step_ff <= 1'b0;
        end else begin
            pc_ff <= nxt_pc;
            pc_step_ff <= nxt_pc_step;
        end
    end

    // post-update acts on the register the pointer held at execution
    aps_aux_bank u_aux_bank (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wr_en(aux_wr_en),
        .wr_sel(aux_wr_sel),
        .wr_data(aux_wr_data),
        .upd_en(aux_upd_en),
        .upd_sel(aux_select_pointer_ff),
        .upd_down(aux_upd_down),
        .aux_zero(aux_register_zero),
        .aux_one(aux_register_one)
    );
endmodule // aps_load_ops
`default_nettype wire

// >>> tb/aps_load_ops_checker.sv
// port checker for the load group
`timescale 1ns/1ps
`default_nettype none
`include "aps_cfg.svh"
module aps_load_ops_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] mem_rdata,
    input wire logic dmem_rd_ff,
    input wire logic [15:0] aux_register_zero,
    input wire logic [15:0] aux_register_one,
    input wire logic aux_select_pointer_ff,
    input wire logic page_pointer_ff,
    input wire logic overflow_flag_ff,
    input wire logic overflow_saturate_mode_ff,
    input wire logic interrupt_mask_bit_ff,
    input wire logic [15:0] status_word_ff,
    input wire logic [11:0] pc_ff,
    input wire logic pc_step_ff
);
    logic [7:0] hi;
    assign hi = instr_word[15:8];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_pc_advance:
    assert property (pc_step_ff |-> pc_ff == $past(pc_ff) + 12'h001)
        else $error("pc step wrong");
    chk_status_image:
    assert property (status_word_ff == {overflow_flag_ff,
        overflow_saturate_mode_ff, interrupt_mask_bit_ff, 4'hf,
        aux_select_pointer_ff, 6'h3f, 1'b0, page_pointer_ff})
        else $error("status image wrong");
    chk_load_aux_immediate_fill:
    assert property (instr_valid && hi[7:1] == `APS_LOAD_AUX_IMMEDIATE_HI |-> ##2
        ($past(instr_word[8], 2) ? aux_register_one : aux_register_zero)
        == {8'h00, $past(instr_word[7:0], 2)}) else $error("aux imm wrong");
    chk_page_imm:
    assert property (instr_valid && instr_word[15:1] == `APS_LOAD_PAGE_IMMEDIATE_HI |-> ##2
        page_pointer_ff == $past(instr_word[0], 2)) else $error("page imm");
    chk_next_pointer:
    assert property (instr_valid && (hi == `APS_MAR_HI || hi == `APS_LST_HI)
        && instr_word[7] && !instr_word[3] |-> ##2
        aux_select_pointer_ff == $past(instr_word[0], 2))
        else $error("pointer wrong");
    chk_page_lsb:
    assert property (dmem_rd_ff && $past(instr_valid && hi == `APS_LDP_HI)
        |=> page_pointer_ff == $past(mem_rdata[0])) else $error("page load");
    chk_status_load:
    assert property (dmem_rd_ff && $past(instr_valid && hi == `APS_LST_HI)
        |=> overflow_saturate_mode_ff == $past(mem_rdata[14])
        && page_pointer_ff == $past(mem_rdata[0])
        && $stable(interrupt_mask_bit_ff)) else $error("status load");
    chk_lar_copy:
    assert property (dmem_rd_ff && $past(instr_valid && hi[7:1] == `APS_LAR_HI)
        |=> ($past(instr_word[8], 2) ? aux_register_one : aux_register_zero)
        == $past(mem_rdata)) else $error("aux load wrong");
    cover property (pc_step_ff && $past(pc_step_ff));
    cover property (dmem_rd_ff && $past(instr_valid && hi == `APS_LST_HI));
    cover property (instr_valid && hi[7:1] == `APS_LAR_HI && instr_word[7]);
endmodule // aps_load_ops_checker
bind aps_load_ops aps_load_ops_checker chk (.*);
`default_nettype wire

// >>> tb/aps_dmem_model.sv
// data memory answering operand reads
`timescale 1ns/1ps
`default_nettype none
module aps_dmem_model (
    input wire logic core_clk,
    input wire logic dmem_rd_ff,
    input wire logic [7:0] dmem_addr_ff,
    output logic [15:0] mem_rdata
);
    logic [15:0] words [256];
    logic [15:0] junk_ff = 16'h5a5a;
    // bus not read shows a changing pattern
    always @(posedge core_clk) junk_ff <= junk_ff + 16'h9e37;
    assign mem_rdata = dmem_rd_ff ? words[dmem_addr_ff] : junk_ff;
endmodule // aps_dmem_model
`default_nettype wire

// >>> tb/aps_load_ops_bench.sv
// self-checking bench for the load group
`timescale 1ns/1ps
`default_nettype none
`include "aps_cfg.svh"
module aps_load_ops_bench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic ov_set = 1'b0;
    logic interrupt_mask_bit_set = 1'b0;
    logic interrupt_mask_bit_clr = 1'b0;
    logic [15:0] mem_rdata, aux_register_zero, aux_register_one;
    logic [15:0] status_word_ff;
    logic [7:0] dmem_addr_ff;
    logic [11:0] pc_ff;
    logic dmem_rd_ff, aux_select_pointer_ff, page_pointer_ff, pc_step_ff;
    logic overflow_flag_ff, overflow_saturate_mode_ff, interrupt_mask_bit_ff;
    logic [59:0] got;
    logic [15:0] ar [2] = '{16'h0000, 16'h0000};
    logic [15:0] img [256];
    logic p = 1'b0, d = 1'b0, ov = 1'b0, overflow_saturate_mode = 1'b0;
    logic im = 1'b1;
    logic [11:0] pc = 12'h000;
    logic [59:0] sq [$];
    logic [7:0] aq [$];
    logic [31:0] seed = 32'h0000694b;
    int n_checks = 0;
    int miscompares = 0;
    logic [15:0] dir [12] = '{16'h3905, 16'h70ff, 16'h7180, 16'h6881,
        16'h6880, 16'h3898, 16'h6e01, 16'h6f01, 16'h7f80, 16'h68a1,
        16'h7b80, 16'h7b02};
    logic [31:0] opt [7] = '{32'h380001ff, 32'h700001ff, 32'h680000ff,
        32'h6f0000ff, 32'h6e000001, 32'h7b0000ff, 32'h7f0000ff};
    aps_load_ops dut (.*);
    aps_dmem_model pm (.*);
    assign got = {aux_register_zero, aux_register_one, status_word_ff, pc_ff};
    always #5 core_clk = ~core_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [15:0] sw();
        return {ov, overflow_saturate_mode, im, 4'hf, p, 6'h3f, 1'b0, d};
    endfunction
    task automatic tally(input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic cmp_state(input logic [59:0] g);
        tally(sq.size() > 0 ? {4'h0, sq.pop_front()} : 64'hx, {4'h0, g});
    endtask
    task automatic cmp_addr(input logic [7:0] g);
        tally(aq.size() > 0 ? {56'h0, aq.pop_front()} : 64'hx, {56'h0, g});
    endtask
    // sequential reference of one instruction, notes its results
    task automatic issue(input logic [15:0] w);
        logic [15:0] m;
        logic [7:0] a;
        logic load_aux_from_memory, mem, adr;
        load_aux_from_memory = w[15:9] == `APS_LAR_HI;
        mem = load_aux_from_memory || w[15:8] == `APS_LDP_HI || w[15:8] == `APS_LST_HI;
        adr = mem || w[15:8] == `APS_MAR_HI;
        a = w[7] ? ar[p][7:0] : {d, w[6:0]};
        m = img[a];
        if (mem) aq.push_back(a);
        if (adr && w[7] && (w[5] ^ w[4]))
            ar[p] = ar[p] + (w[5] ? 16'h0001 : 16'hffff);
        if (load_aux_from_memory) ar[w[8]] = m;
        if (w[15:8] == `APS_LDP_HI) d = m[0];
        if (w[15:8] == `APS_LST_HI)
            {ov, overflow_saturate_mode, p, d} = {m[15], m[14], m[8], m[0]};
        if (adr && w[7] && !w[3]) p = w[0];
        if (w[15:9] == `APS_LOAD_AUX_IMMEDIATE_HI) ar[w[8]] = {8'h00, w[7:0]};
        if (w[15:1] == `APS_LOAD_PAGE_IMMEDIATE_HI) d = w[0];
        if (adr || w[15:9] == `APS_LOAD_AUX_IMMEDIATE_HI || w[15:1] == `APS_LOAD_PAGE_IMMEDIATE_HI) begin
            pc = pc + 12'h001;
            sq.push_back({ar[0], ar[1], sw(), pc});
        end
    endtask
    task automatic cyc(input logic v, input logic [15:0] w);
        @(posedge core_clk);
        instr_valid <= v;
        instr_word <= w;
        if (v) issue(w);
    endtask
    // one-cycle pulse of overflow set, mask set, mask clear
    task automatic pulse(input logic [2:0] f);
        @(posedge core_clk);
        instr_valid <= 1'b0;
        {ov_set, interrupt_mask_bit_set, interrupt_mask_bit_clr} <= f;
        if (f[2]) ov = 1'b1;
        if (f[1]) im = 1'b1;
        else if (f[0]) im = 1'b0;
        @(posedge core_clk);
        {ov_set, interrupt_mask_bit_set, interrupt_mask_bit_clr} <= 3'b000;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge core_clk) begin
        if (rst_n && pc_step_ff === 1'b1) cmp_state(got);
        if (rst_n && dmem_rd_ff === 1'b1) cmp_addr(dmem_addr_ff);
    end
    initial begin
        logic [2:0] k;
        foreach (img[i]) begin
            seed = xs(seed);
            img[i] = seed[15:0];
        end
        img[8'h81] = 16'hfedc;
        pm.words = img;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        sq.push_back({ar[0], ar[1], sw(), pc});
        cmp_state(got);
        $display("reset test done");
        foreach (dir[i]) cyc(1'b1, dir[i]);
        repeat (3) cyc(1'b0, 16'h0000);
        pulse(3'b101);
        cyc(1'b1, 16'h6e00);
        cyc(1'b1, 16'h7b02);
        repeat (2) cyc(1'b0, 16'h0000);
        pulse(3'b011);
        $display("directed test done");
        repeat (600) begin
            seed = xs(seed);
            k = 3'(seed[18:16] % 7);
            cyc(seed[0] | seed[1],
                opt[k][31:16] | (seed[15:0] & opt[k][15:0]));
        end
        cyc(1'b0, 16'h0000);
        for (int t = 0; t < 8 && sq.size() + aq.size() > 0; t++)
            @(posedge core_clk);
        if (sq.size() + aq.size() > 0) miscompares++;
        $display("random test done");
        wrap_up();
    end
endmodule // aps_load_ops_bench
`default_nettype wire
